// ### rtl/tcmc_pkg.sv
// Purpose: Constants, register map and state types for the channel-pair
//          mode control block.
// Assumes: 32-bit AHB-Lite register access, one word per register.
// Notes:   Filter and prescaler lookups live here as constant functions.
package tcmc_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_CV0 = 8'h08;
    localparam logic [7:0] OFF_CV1 = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam int CH_STRIDE = 8;
    localparam int MS_LSB = 0;
    localparam int FAST_BIT = 2;
    localparam int BUF_BIT = 3;
    localparam int LOCK_LSB = 3;
    localparam int FN_LSB = 4;
    localparam int CLR_BIT = 7;
    localparam int FLT_LSB = 4;
    localparam int PSC_LSB = 2;
    localparam int CFG_EN_LSB = 0;
    localparam int CFG_MPOL_LSB = 2;
    localparam int CFG_NPOL_LSB = 4;
    localparam int CFG_WRITE_PROTECTION_LEVEL_LSB = 6;
    localparam logic [1:0] MS_OUT = 2'h0;
    localparam logic [1:0] MS_OWN = 2'h1;
    localparam logic [1:0] MS_NBR = 2'h2;
    localparam logic [1:0] MS_ITS = 2'h3;
    localparam logic [1:0] WRITE_PROTECTION_LEVEL_LOCK = 2'h3;
    localparam logic [2:0] FN_TIMING = 3'h0;
    localparam logic [2:0] FN_SET = 3'h1;
    localparam logic [2:0] FN_CLR = 3'h2;
    localparam logic [2:0] FN_TOG = 3'h3;
    localparam logic [2:0] FN_LOW = 3'h4;
    localparam logic [2:0] FN_HIGH = 3'h5;
    localparam logic [2:0] FN_PWM0 = 3'h6;
    localparam logic [2:0] FN_PWM1 = 3'h7;
    localparam logic [3:0] FLT_OFF = 4'h0;
    localparam logic [3:0] FLT_FIRST_DTS = 4'h4;

    typedef struct packed {
        logic prep;
        logic [2:0] prev_fn;
        logic prev_lvl;
        logic [15:0] cv_pre;
        logic [15:0] cv_act;
        logic [3:0] flt_cnt;
        logic flt_lvl;
        logic sel_d;
        logic [2:0] psc;
    } tcmc_chan_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [7:0] cfg;
        tcmc_chan_t [1:0] ch;
        logic [4:0] dts_div;
        logic trig_d;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic readyout;
        logic [1:0] main;
        logic [1:0] comp;
        logic [1:0] capture;
    } tcmc_state_t;

    // Identical samples needed before a new level is passed
    function automatic logic [3:0] flt_need(input logic [3:0] code);
        case (code)
            4'h1: return 4'h2;
            4'h2: return 4'h4;
            4'h4, 4'h6, 4'h8, 4'hb, 4'he: return 4'h6;
            4'ha, 4'hd: return 4'h5;
            default: return 4'h8;
        endcase
    endfunction

    // Divider mask on the dead-time tick count for the sample rate
    function automatic logic [4:0] flt_mask(input logic [3:0] code);
        case (code)
            4'h4, 4'h5: return 5'h01;
            4'h6, 4'h7: return 5'h03;
            4'h8, 4'h9: return 5'h07;
            4'ha, 4'hb, 4'hc: return 5'h0f;
            4'hd, 4'he, 4'hf: return 5'h1f;
            default: return 5'h00;
        endcase
    endfunction

    function automatic logic [2:0] psc_limit(input logic [1:0] code);
        case (code)
            2'h1: return 3'h1;
            2'h2: return 3'h3;
            2'h3: return 3'h7;
            default: return 3'h0;
        endcase
    endfunction
endpackage

// ### rtl/tcmc_top.sv
// Purpose: Mode control for timer channels 0 and 1: compare output
//          functions, compare buffering, capture filter and prescaler.
// Assumes: Counter, direction, update and trigger come from the timer
//          kernel; i_dts_tick pulses once per dead-time sample period.
// Notes:   Registers on AHB-Lite, zero wait states, always OKAY.
//
// Summary of operation
// RQ1: Code 000 holds the prepared output, ignoring compare matches.
// RQ2: Code 001 sets the prepared output high on counter equal compare.
// RQ3: Code 010 clears the prepared output on counter equal compare.
// RQ4: Code 011 toggles the prepared output on every equal match.
// RQ5: Code 100 forces output low, code 101 forces it high.
// RQ6: Code 110: up high below compare; down low above compare.
// RQ7: Code 111 is the inverse of code 110 in both directions.
// RQ8: Pulse-width output changes only on comparison change or leaving 000.
// RQ9: Prepared high is active; main and complementary polarity separately.
// RQ10: Function and buffering bits locked at protection 11 in output mode.
// RQ11: Buffering on: compare value goes to shadow, active at update.
// RQ12: Software buffers pulse-width compare unless single-pulse is used.
// RQ13: Accelerate bit: trigger edge acts as match in pulse-width modes.
// RQ14: Mode 00 output, 01 own input, 10 neighbour, 11 trigger.
// RQ15: Mode field writable only while channel enable is clear.
// RQ16: Software selects trigger source before choosing mode 11.
// RQ17: Field layout: function 6:4, buffer 3, accelerate 2, mode 1:0.
// RQ18: Filter passes a level after enough consecutive equal samples.
// RQ19: Filter code picks sample count and sampling rate.
// RQ20: Prescaler captures every 1, 2, 4 or 8 qualifying edges.
// RQ21: Prescaler edge count resets while channel enable is clear.
// RQ22: Channel 1 fields in the upper byte behave as channel 0.
// RQ23: Reference clear forces prepared output low while trigger is high.
// RQ24: Comparisons use the active compare value every clock.
`timescale 1ns/1ns
module tcmc_top
    import tcmc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic [15:0] i_cnt,
    input wire logic i_dir_down,
    input wire logic i_update,
    input wire logic i_trig,
    input wire logic i_ext_trig,
    input wire logic i_its,
    input wire logic i_dts_tick,
    input wire logic [1:0] i_ch_in,
    output logic [1:0] o_main,
    output logic [1:0] o_comp,
    output logic [1:0] o_capture
);
    tcmc_state_t s;
    tcmc_state_t next_s;

    function automatic logic [15:0] ctrl_wr(input logic [15:0] old,
        input logic [15:0] wd, input logic [1:0] en, input logic [1:0] write_protection_level);
        logic [15:0] r;
        r = wd;
        for (int c = 0; c < 2; c++) begin
            if (en[c]) begin
                r[c*CH_STRIDE+MS_LSB +: 2] = old[c*CH_STRIDE+MS_LSB +: 2];
            end
            if (write_protection_level == WRITE_PROTECTION_LEVEL_LOCK &&
                old[c*CH_STRIDE+MS_LSB +: 2] == MS_OUT) begin
                r[c*CH_STRIDE+LOCK_LSB +: 4] = old[c*CH_STRIDE+LOCK_LSB +: 4];
            end
        end
        return r;
    endfunction

    function automatic logic pwm_lvl(input logic [2:0] fn,
        input logic [15:0] cnt, input logic [15:0] cv, input logic down);
        logic l;
        l = down ? !(cnt > cv) : (cnt < cv);
        return (fn == FN_PWM1) ? !l : l;
    endfunction

    function automatic logic [31:0] rd_mux(input tcmc_state_t st,
        input logic [7:0] a);
        case (a)
            OFF_CTRL: return {16'h0000, st.ctrl};
            OFF_CFG: return {24'h000000, st.cfg};
            OFF_CV0: return {16'h0000, st.ch[0].cv_pre};
            OFF_CV1: return {16'h0000, st.ch[1].cv_pre};
            OFF_STAT: return {26'h0000000, st.ch[1].flt_lvl,
                st.ch[0].flt_lvl, st.ch[1].sel_d, st.ch[0].sel_d,
                st.ch[1].prep, st.ch[0].prep};
            default: return 32'h00000000;
        endcase
    endfunction

    always_comb begin
        logic [7:0] b;
        logic [1:0] ms;
        logic [2:0] fn;
        logic [3:0] flt;
        logic [15:0] cv;
        logic pwm;
        logic lvl;
        logic p;
        logic smp;
        logic din;
        logic sel;
        logic en;
        logic trig_edge;
        b = 8'h00;
        ms = MS_OUT;
        fn = FN_TIMING;
        flt = FLT_OFF;
        cv = 16'h0000;
        pwm = 1'b0;
        lvl = 1'b0;
        p = 1'b0;
        smp = 1'b0;
        din = 1'b0;
        sel = 1'b0;
        en = 1'b0;
        trig_edge = i_trig & ~s.trig_d;
        next_s = s;
        next_s.capture = 2'h0;
        next_s.readyout = 1'b1;
        next_s.trig_d = i_trig;
        next_s.dts_div = s.dts_div + {4'h0, i_dts_tick};

        // Data phase of a write from the previous address phase
        if (s.wr_pend) begin
            case (s.wr_addr)
                OFF_CTRL: next_s.ctrl = ctrl_wr(s.ctrl, i_hwdata[15:0],
                    s.cfg[CFG_EN_LSB +: 2], s.cfg[CFG_WRITE_PROTECTION_LEVEL_LSB +: 2]); // see RQ10 RQ15
                OFF_CFG: next_s.cfg = i_hwdata[7:0];
                OFF_CV0: next_s.ch[0].cv_pre = i_hwdata[15:0];
                OFF_CV1: next_s.ch[1].cv_pre = i_hwdata[15:0];
                default: next_s.ctrl = s.ctrl;
            endcase
        end
        next_s.wr_pend = i_hsel & i_hready & i_htrans[1] & i_hwrite;
        next_s.wr_addr = {i_haddr[7:2], 2'b00};
        if (i_hsel & i_hready & i_htrans[1] & ~i_hwrite) begin
            next_s.hrdata = rd_mux(s, {i_haddr[7:2], 2'b00});
        end

        for (int c = 0; c < 2; c++) begin
            b = s.ctrl[c*CH_STRIDE +: CH_STRIDE]; // see RQ17 RQ22
            ms = b[MS_LSB +: 2];
            fn = b[FN_LSB +: 3];
            flt = b[FLT_LSB +: 4];
            en = s.cfg[CFG_EN_LSB + c];

            // Shadow copy loads at update; unbuffered uses the written value
            if (i_update) begin
                next_s.ch[c].cv_act = s.ch[c].cv_pre; // see RQ11
            end
            cv = b[BUF_BIT] ? s.ch[c].cv_act : s.ch[c].cv_pre; // see RQ11 RQ24

            pwm = (fn == FN_PWM0) || (fn == FN_PWM1);
            lvl = pwm_lvl(fn, i_cnt, cv, i_dir_down); // see RQ6 RQ7 RQ24
            p = s.ch[c].prep;
            if (ms == MS_OUT) begin
                case (fn)
                    FN_TIMING: p = s.ch[c].prep; // see RQ1
                    FN_SET: if (i_cnt == cv) p = 1'b1; // see RQ2
                    FN_CLR: if (i_cnt == cv) p = 1'b0; // see RQ3
                    FN_TOG: if (i_cnt == cv) p = ~s.ch[c].prep; // see RQ4
                    FN_LOW: p = 1'b0; // see RQ5
                    FN_HIGH: p = 1'b1; // see RQ5
                    default: begin
                        if (lvl != s.ch[c].prev_lvl ||
                            s.ch[c].prev_fn == FN_TIMING) begin
                            p = lvl; // see RQ8
                        end
                    end
                endcase
                // Trigger edge acts as a match: take the level at equality
                if (b[FAST_BIT] && pwm && trig_edge) begin
                    p = pwm_lvl(fn, cv, cv, i_dir_down); // see RQ13
                end
                if (b[CLR_BIT] && i_ext_trig) begin
                    p = 1'b0; // see RQ23
                end
            end
            next_s.ch[c].prep = p;
            next_s.ch[c].prev_lvl = lvl;
            next_s.ch[c].prev_fn = fn;
            next_s.main[c] = p ^ s.cfg[CFG_MPOL_LSB + c]; // see RQ9
            next_s.comp[c] = ~p ^ s.cfg[CFG_NPOL_LSB + c]; // see RQ9

            // Digital filter on the channel input
            din = i_ch_in[c];
            smp = (flt < FLT_FIRST_DTS) ? 1'b1 :
                (i_dts_tick &&
                 ((s.dts_div & flt_mask(flt)) == flt_mask(flt))); // see RQ19
            if (flt == FLT_OFF) begin
                next_s.ch[c].flt_lvl = din; // see RQ19
                next_s.ch[c].flt_cnt = 4'h0;
            end else if (smp) begin
                if (din == s.ch[c].flt_lvl) begin
                    next_s.ch[c].flt_cnt = 4'h0; // see RQ18
                end else if (s.ch[c].flt_cnt + 4'h1 >= flt_need(flt)) begin
                    next_s.ch[c].flt_lvl = din; // see RQ18
                    next_s.ch[c].flt_cnt = 4'h0;
                end else begin
                    next_s.ch[c].flt_cnt = s.ch[c].flt_cnt + 4'h1;
                end
            end

            // Input selection, edge detect and capture prescaler
            case (ms)
                MS_OWN: sel = s.ch[c].flt_lvl; // see RQ14
                MS_NBR: sel = s.ch[1-c].flt_lvl; // see RQ14
                MS_ITS: sel = i_its; // see RQ14
                default: sel = 1'b0;
            endcase
            next_s.ch[c].sel_d = sel;
            if (!en) begin
                next_s.ch[c].psc = 3'h0; // see RQ21
            end else if (ms != MS_OUT && sel && !s.ch[c].sel_d) begin
                if (s.ch[c].psc >= psc_limit(b[PSC_LSB +: 2])) begin
                    next_s.capture[c] = 1'b1; // see RQ20
                    next_s.ch[c].psc = 3'h0;
                end else begin
                    next_s.ch[c].psc = s.ch[c].psc + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s <= '0;
            s.readyout <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign o_hreadyout = s.readyout;
    assign o_hresp = 1'b0;
    assign o_hrdata = s.hrdata;
    assign o_main = s.main;
    assign o_comp = s.comp;
    assign o_capture = s.capture;

    // Helper view of channel 0 for the checks below
    logic [2:0] a_fn;
    logic a_out;
    logic a_match;
    logic a_clr;
    assign a_fn = s.ctrl[FN_LSB +: 3];
    assign a_out = s.ctrl[MS_LSB +: 2] == MS_OUT;
    assign a_clr = s.ctrl[CLR_BIT] & i_ext_trig;
    assign a_match = i_cnt == (s.ctrl[BUF_BIT] ? s.ch[0].cv_act :
        s.ch[0].cv_pre);

    default clocking a_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    AST_HOLD: assert property (a_out && a_fn == FN_TIMING && !a_clr // see RQ1
        |=> $stable(s.ch[0].prep))
        else $error("timing mode changed the prepared output");
    AST_SET: assert property (a_out && a_fn == FN_SET && a_match && !a_clr // see RQ2
        |=> s.ch[0].prep && s.main[0] == (1'b1 ^ $past(s.cfg[CFG_MPOL_LSB])))
        else $error("set on match failed");
    AST_CLEAR: assert property (a_out && a_fn == FN_CLR && a_match // see RQ3
        |=> !s.ch[0].prep)
        else $error("clear on match failed");
    AST_TOGGLE: assert property (a_out && a_fn == FN_TOG && a_match && !a_clr // see RQ4
        |=> s.ch[0].prep != $past(s.ch[0].prep))
        else $error("toggle on match failed");
    AST_FORCE: assert property (a_out && a_fn == FN_HIGH && !a_clr // see RQ5
        |=> s.ch[0].prep)
        else $error("force high failed");
    AST_REF_CLEAR: assert property (a_out && a_clr // see RQ23
        |=> !s.ch[0].prep)
        else $error("reference clear did not clear the output");
    AST_MODE_LOCK: assert property (s.cfg[CFG_EN_LSB] && s.wr_pend // see RQ15
        && s.wr_addr == OFF_CTRL |=> $stable(s.ctrl[MS_LSB +: 2]))
        else $error("mode field written while channel enabled");
    AST_WRITE_PROTECTION_LEVEL_LOCK: assert property (a_out && s.wr_pend // see RQ10
        && s.cfg[CFG_WRITE_PROTECTION_LEVEL_LSB +: 2] == WRITE_PROTECTION_LEVEL_LOCK && s.wr_addr == OFF_CTRL
        |=> $stable(s.ctrl[LOCK_LSB +: 4]))
        else $error("locked compare fields changed");
    AST_PSC_RESET: assert property (!s.cfg[CFG_EN_LSB] // see RQ21
        |=> s.ch[0].psc == 3'h0 && !s.capture[0])
        else $error("prescaler not held in reset while disabled");
endmodule

// ### sim/test_timer_channel_mode_control.sv
// Purpose: Self-checking bench for the channel-pair mode control block.
// Assumes: Zero-wait AHB-Lite slave; channel 0 cycle model in the bench.
// Notes:   Outputs are compared only where the model level is settled.
`timescale 1ns/1ns
module test_timer_channel_mode_control;
    import tcmc_pkg::*;
    logic i_clk;
    logic i_rstn;
    logic i_hsel;
    logic [31:0] i_haddr;
    logic [1:0] i_htrans;
    logic i_hwrite;
    logic [2:0] i_hsize;
    logic [31:0] i_hwdata;
    wire logic i_hready;
    logic o_hreadyout;
    logic o_hresp;
    logic [31:0] o_hrdata;
    logic [15:0] i_cnt;
    logic i_dir_down;
    logic i_update;
    logic i_trig;
    logic i_ext_trig;
    logic i_its;
    logic i_dts_tick;
    logic [1:0] i_ch_in;
    logic [1:0] o_main;
    logic [1:0] o_comp;
    logic [1:0] o_capture;
    int failures = 0;
    int n_compared = 0;
    int seed = 81;
    int hold = 8;
    int cap[2];
    bit chk_on = 0;
    bit stim_on = 0;
    logic [15:0] mc = 16'h0000;
    logic [7:0] mg = 8'h00;
    logic [15:0] mcv = 16'h0000;
    logic [15:0] m_cva;
    logic m_prep;
    logic m_old;
    logic m_plvl;
    logic m_trig_d;
    logic [2:0] m_pfn;
    int fcode[8] = '{1, 1, 3, 3, 4, 4, 15, 15};
    int fhi[8] = '{1, 4, 5, 12, 14, 40, 100, 600};
    int fexp[8] = '{0, 3, 0, 3, 0, 3, 0, 3};

    assign i_hready = o_hreadyout;

    tcmc_top uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
        .i_cnt(i_cnt), .i_dir_down(i_dir_down), .i_update(i_update),
        .i_trig(i_trig), .i_ext_trig(i_ext_trig), .i_its(i_its),
        .i_dts_tick(i_dts_tick), .i_ch_in(i_ch_in), .o_main(o_main),
        .o_comp(o_comp), .o_capture(o_capture));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    always @(posedge i_clk) i_dts_tick <= ~i_dts_tick;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Expected control word after lock rules on enable and protection
    function automatic logic [15:0] ctl_next(input logic [15:0] wd);
        logic [15:0] r;
        r = wd;
        for (int c = 0; c < 2; c++) begin
            if (mg[c]) r[c*8 +: 2] = mc[c*8 +: 2];
            if (mg[7:6] == WRITE_PROTECTION_LEVEL_LOCK && mc[c*8 +: 2] == MS_OUT)
                r[c*8+3 +: 4] = mc[c*8+3 +: 4];
        end
        return r;
    endfunction

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        int k;
        k = 0;
        i_hsel <= 1'b1;
        i_haddr <= {24'h0, a};
        i_htrans <= 2'h2;
        i_hwrite <= w;
        do begin @(posedge i_clk); k++; end
        while (o_hreadyout !== 1'b1 && k < 50);
        i_htrans <= 2'h0;
        i_hsel <= 1'b0;
        i_hwdata <= wd;
        do begin @(posedge i_clk); k++; end
        while (o_hreadyout !== 1'b1 && k < 100);
        rd = o_hrdata;
        if (k >= 100) failures++;
        if (w && a == OFF_CTRL) mc <= ctl_next(wd[15:0]);
        if (w && a == OFF_CFG) mg <= wd[7:0];
        if (w && a == OFF_CFG) hold = 4;
        if (w && a == OFF_CV0) mcv <= wd[15:0];
    endtask

    task automatic pulse(input int src, input int hi);
        if (src == 2) i_its <= 1'b1; else i_ch_in[src] <= 1'b1;
        repeat (hi) @(posedge i_clk);
        if (src == 2) i_its <= 1'b0; else i_ch_in[src] <= 1'b0;
        repeat (hi) @(posedge i_clk);
    endtask

    task automatic cap_run(input int c, input logic [7:0] f, input int src,
                           input int n, input int hi, output int got);
        logic [31:0] d;
        bus(OFF_CFG, 1'b1, 32'h0, d);
        bus(OFF_CTRL, 1'b1, {16'h0, f} << (8 * c), d);
        bus(OFF_CFG, 1'b1, 32'(1 << c), d);
        cap[c] = 0;
        repeat (n) pulse(src, hi);
        repeat (40) @(posedge i_clk);
        got = cap[c];
        bus(OFF_CFG, 1'b1, 32'h0, d);
    endtask

    // Channel 0 prepared level, sampled like the design at each edge
    always @(posedge i_clk or negedge i_rstn) begin
        logic [2:0] fn;
        logic [15:0] cv;
        logic lvl;
        if (!i_rstn) begin
            {m_prep, m_old, m_plvl, m_trig_d, m_pfn, m_cva} = '0;
        end else begin
            m_old = m_prep;
            fn = mc[6:4];
            cv = mc[3] ? m_cva : mcv;
            lvl = i_dir_down ? !(i_cnt > cv) : (i_cnt < cv);
            if (fn == FN_PWM1) lvl = !lvl;
            if (mc[1:0] == MS_OUT) begin
                case (fn)
                    FN_SET: if (i_cnt == cv) m_prep = 1'b1;
                    FN_CLR: if (i_cnt == cv) m_prep = 1'b0;
                    FN_TOG: if (i_cnt == cv) m_prep = !m_prep;
                    FN_LOW: m_prep = 1'b0;
                    FN_HIGH: m_prep = 1'b1;
                    FN_PWM0, FN_PWM1: begin
                        if (lvl != m_plvl || m_pfn == FN_TIMING) m_prep = lvl;
                        if (mc[2] && i_trig && !m_trig_d)
                            m_prep = (fn == FN_PWM0) ? i_dir_down : !i_dir_down;
                    end
                    default: m_prep = m_prep;
                endcase
                if (mc[7] && i_ext_trig) m_prep = 1'b0;
            end
            m_plvl = lvl;
            m_pfn = fn;
            m_trig_d = i_trig;
            if (i_update) m_cva = mcv;
        end
    end

    always @(posedge i_clk) begin
        if (stim_on) begin
            i_cnt <= mcv + 16'($random(seed) % 3);
            i_trig <= 1'($random(seed));
            i_ext_trig <= 1'($random(seed));
            i_update <= 1'($random(seed));
        end
    end

    always @(negedge i_clk) begin
        if (o_capture[0] === 1'b1) cap[0]++;
        if (o_capture[1] === 1'b1) cap[1]++;
        if (hold > 0) hold--;
        else if (chk_on && m_old === m_prep)
            check({30'h0, o_comp[0], o_main[0]},
                {30'h0, ~m_prep ^ mg[4], m_prep ^ mg[2]});
    end

    initial begin
        repeat (60000) @(posedge i_clk);
        failures++;
        wrap_up();
    end

    initial begin
        logic [31:0] d;
        int got;
        int src;
        {i_rstn, i_hsel, i_haddr, i_htrans, i_hwrite, i_hwdata} = '0;
        {i_cnt, i_dir_down, i_update, i_trig, i_ext_trig, i_its} = '0;
        i_hsize = 3'h2;
        i_dts_tick = 1'b0;
        i_ch_in = 2'h0;
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk_on = 1'b1;
        check({29'h0, o_hresp, o_comp}, 32'h3);
        for (int k = 0; k < 6; k++) begin
            bus(8'(k * 4), 1'b0, 32'h0, d);
            check(d, 32'h0);
        end
        bus(OFF_CV1, 1'b1, 32'h1234abcd, d);
        bus(OFF_CV1, 1'b0, 32'h0, d);
        check(d, 32'h0000abcd);
        for (int fn = 1; fn < 8; fn++) begin
            for (int dn = 0; dn < 2; dn++) begin
                i_dir_down <= dn[0];
                bus(OFF_CFG, 1'b1, 32'($random(seed)) & 32'h14, d);
                bus(OFF_CV0, 1'b1, 32'd1000 + (32'($random(seed)) & 32'h3ff),
                    d);
                bus(OFF_CTRL, 1'b1, 32'h0, d);
                bus(OFF_CTRL, 1'b1, 32'((dn << 7) | (fn << 4) | 4 |
                    ((fn >= 6) ? 8 : 0)), d);
                stim_on = 1'b1;
                repeat (30) @(posedge i_clk);
                stim_on = 1'b0;
            end
        end
        i_trig <= 1'b0;
        i_ext_trig <= 1'b0;
        i_update <= 1'b0;
        i_cnt <= 16'd200;
        bus(OFF_CTRL, 1'b1, 32'h48, d);
        bus(OFF_CTRL, 1'b1, 32'h18, d);
        bus(OFF_CV0, 1'b1, 32'd200, d);
        repeat (3) @(posedge i_clk);
        check({31'h0, o_main[0] ^ mg[2]}, 32'h0);
        i_update <= 1'b1;
        @(posedge i_clk);
        i_update <= 1'b0;
        repeat (3) @(posedge i_clk);
        check({31'h0, o_main[0] ^ mg[2]}, 32'h1);
        bus(OFF_STAT, 1'b0, 32'h0, d);
        check(d, {31'h0, m_prep});
        bus(OFF_CFG, 1'b1, 32'hc0, d);
        bus(OFF_CTRL, 1'b1, 32'h21f4, d);
        bus(OFF_CTRL, 1'b0, 32'h0, d);
        check(d, {16'h0, mc});
        bus(OFF_CTRL, 1'b1, 32'h2501, d);
        bus(OFF_CTRL, 1'b0, 32'h0, d);
        check(d, {16'h0, mc});
        bus(OFF_CFG, 1'b1, 32'h03, d);
        bus(OFF_CTRL, 1'b1, 32'h0202, d);
        bus(OFF_CTRL, 1'b0, 32'h0, d);
        check(d, {16'h0, mc});
        bus(8'h20, 1'b1, 32'hffff, d);
        bus(OFF_CTRL, 1'b0, 32'h0, d);
        check(d, {16'h0, mc});
        for (int c = 0; c < 2; c++) begin
            for (int m = 1; m < 4; m++) begin
                for (int p = 0; p < 4; p++) begin
                    src = (m == 1) ? c : ((m == 2) ? 1 - c : 2);
                    cap_run(c, 8'((p << 2) | m), src, 9, 3, got);
                    check(32'(got), 32'(9 >> p));
                end
            end
        end
        cap_run(0, 8'h0d, 0, 5, 3, got);
        check(32'(got), 32'h0);
        cap_run(0, 8'h0d, 0, 5, 3, got);
        check(32'(got), 32'h0);
        for (int k = 0; k < 8; k++) begin
            cap_run(0, 8'((fcode[k] << 4) | 1), 0, 3, fhi[k], got);
            check(32'(got), 32'(fexp[k]));
        end
        // Channel 1 compare outputs with its own polarity bits
        bus(OFF_CFG, 1'b1, 32'h08, d);
        bus(OFF_CTRL, 1'b1, 32'h5000, d);
        repeat (2) @(posedge i_clk);
        check({30'h0, o_comp[1], o_main[1]}, 32'h0);
        bus(OFF_CTRL, 1'b1, 32'h4000, d);
        repeat (2) @(posedge i_clk);
        check({30'h0, o_comp[1], o_main[1]}, 32'h3);
        wrap_up();
    end
endmodule
